// ---- design/spc_pkg.sv ----
// Purpose: Shared constants and carriers for the switch port configuration bank
// Assumes: Dword-aligned configuration offsets, 32-bit data
// Notes:   Offsets are byte addresses within configuration space
package spc_pkg;

    // Register offsets
    localparam logic [7:0] OFF_LINK_STAT2   = 8'h98;
    localparam logic [7:0] OFF_SLOT_CAP2    = 8'h9c;
    localparam logic [7:0] OFF_SLOT_CTL2    = 8'ha0;
    localparam logic [7:0] OFF_SUBSYS_HDR   = 8'ha4;
    localparam logic [7:0] OFF_SUBSYS_CODE  = 8'ha8;
    localparam logic [7:0] OFF_MSIX_CTRL    = 8'hb0;
    localparam logic [7:0] OFF_MSIX_TABLE   = 8'hb4;
    localparam logic [7:0] OFF_MSIX_PEND    = 8'hb8;
    localparam logic [7:0] OFF_VENDOR_HDR   = 8'hc8;
    localparam logic [7:0] OFF_WIN0         = 8'he0;
    localparam logic [7:0] OFF_WIN1         = 8'he4;
    localparam logic [7:0] OFF_WIN2         = 8'he8;
    localparam logic [7:0] OFF_WIN3         = 8'hec;

    // Link status upper half bit positions
    localparam int LS_DEEMPH   = 16;
    localparam int LS_EQ_DONE  = 17;
    localparam int LS_EQ_PH1   = 18;
    localparam int LS_EQ_REQ   = 21;
    localparam int LS_PRES_LO  = 28;
    localparam int LS_DRS      = 31;
    localparam logic       DEEMPH_RESET = 1'b1;

    // Presence codes
    localparam logic [2:0] PRES_DOWN_UNKNOWN = 3'h0;
    localparam logic [2:0] PRES_DOWN_ABSENT  = 3'h1;
    localparam logic [2:0] PRES_DOWN_PRESENT = 3'h2;
    localparam logic [2:0] PRES_UP_PRESENT   = 3'h4;
    localparam logic [2:0] PRES_UP_DRS       = 3'h5;

    // Capability constants
    localparam logic [7:0]  SUBSYS_CAP_ID    = 8'h0d;
    localparam logic [7:0]  SUBSYS_NEXT      = 8'hb0;
    localparam logic [7:0]  MSIX_CAP_ID      = 8'h11;
    localparam logic [7:0]  MSIX_NEXT        = 8'hc8;
    localparam logic [10:0] MSIX_TABLE_SIZE  = 11'h005;
    localparam int          MSIX_VECTORS     = 6;
    localparam int          MSIX_FMASK_BIT   = 30;
    localparam int          MSIX_EN_BIT      = 31;
    localparam logic [2:0]  MSIX_WIN_IND     = 3'h0;
    localparam logic [28:0] MSIX_TABLE_OFS   = 29'h0000_fe00;
    localparam logic [28:0] MSIX_PEND_OFS    = 29'h0000_fe10;
    localparam logic [7:0]  VENDOR_CAP_ID    = 8'h09;
    localparam logic [7:0]  VENDOR_NEXT      = 8'h00;
    localparam logic [15:0] VENDOR_LEN       = 16'h0038;

    // Window setup fields
    localparam logic [1:0]  WTYPE_32         = 2'h0;
    localparam logic [1:0]  WTYPE_64         = 2'h2;
    localparam logic [3:0]  FABRIC_MAX       = 4'h5;
    localparam logic [3:0]  PARTITION_MAX    = 4'hb;
    // Writable bits of each setup word when the window pair is 32-bit, then reset values of each word
    localparam logic [31:0] WIN0_WMASK       = 32'hfff8_0006 | 32'h0000_0008;
    localparam logic [31:0] WIN2_WMASK       = 32'hfff0_01fe;
    localparam logic [31:0] WIN_ODD_WMASK    = 32'hfff0_01e8;
    localparam logic [31:0] WIN0_RESET       = 32'hfff8_0000;
    localparam logic [31:0] WIN1_RESET       = 32'h0000_0000;
    localparam logic [31:0] WIN2_RESET       = 32'hfff0_0000;
    localparam logic [31:0] WIN3_RESET       = 32'h0000_0000;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } spc_cfg_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } spc_cfg_rsp_s;

    typedef struct packed {
        logic       deemph_35;
        logic       eq_done;
        logic [2:0] eq_phase_ok;
        logic       eq_req_pulse;
        logic [2:0] presence;
        logic       drs_msg_pulse;
    } spc_link_evt_s;

    typedef struct packed {
        logic                    enable;
        logic                    func_mask;
        logic                    msix_allowed;
        logic                    intx_allowed;
        logic [MSIX_VECTORS-1:0] vector_masked;
    } spc_msix_s;

    typedef struct packed {
        logic [3:0]  enable;
        logic [1:0]  pair64;
        logic [3:0]  prefetch;
        logic        trans_direct;
        logic [3:0]  fabric_number;
        logic [3:0]  partition_number;
        logic [63:0] mask01;
        logic [63:0] mask23;
        logic [31:0] mask1;
        logic [31:0] mask3;
    } spc_win_s;

endpackage

// ---- design/spc_cfg_regs.sv ----
// Purpose: Configuration register bank for one switch port
// Assumes: Requests come from logic on core_clk_in; answer one cycle later
// Notes:   Window setup outputs feed the address decode and translation logic
`timescale 1ns/1ps
`default_nettype none

module spc_cfg_regs #(
    parameter logic [15:0] SUBSYS_VENDOR_CODE = 16'h1111, // Arbitrary value
    parameter logic [15:0] SUBSYS_DEVICE_CODE = 16'h2222  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    srst_in,
    // Configuration access
    input  wire spc_pkg::spc_cfg_req_s   cfg_req_in,
    output var  spc_pkg::spc_cfg_rsp_s   cfg_rsp_out,
    // Link status events
    input  wire spc_pkg::spc_link_evt_s  link_evt_in,
    // Interrupt steering
    input  wire logic                    msi_enable_in,
    input  wire logic [5:0]              vector_mask_in,
    output var  spc_pkg::spc_msix_s      msix_out,
    // Window setup
    output var  spc_pkg::spc_win_s       win_out
);
    import spc_pkg::*;

    typedef struct packed {
        logic          deemph;
        logic          eq_done;
        logic [2:0]    eq_phase_ok;
        logic          eq_req;
        logic [2:0]    presence;
        logic          drs_rx;
        logic          msix_en;
        logic          msix_fmask;
        logic [31:0]   win0;
        logic [31:0]   win1;
        logic [31:0]   win2;
        logic [31:0]   win3;
        spc_cfg_rsp_s  rsp;
        spc_msix_s     msix;
        spc_win_s      win;
    } spc_state_s;

    spc_state_s state_reg;
    spc_state_s state_next;

    logic [31:0] wmask;
    logic [31:0] merged;
    logic [31:0] win1_view;
    logic [31:0] win3_view;
    logic [31:0] rdata;
    logic        wr_hit;
    logic        rd_hit;
    logic        is64_01;
    logic        is64_23;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cfg_req_in.be[i]}};
        end
    end

    assign wr_hit  = cfg_req_in.valid && cfg_req_in.write;
    assign rd_hit  = cfg_req_in.valid && !cfg_req_in.write;
    assign is64_01 = (state_reg.win0[2:1] == WTYPE_64);
    assign is64_23 = (state_reg.win2[2:1] == WTYPE_64);

    // Odd words show only their 32-bit fields unless paired
    assign win1_view = is64_01 ? state_reg.win1 : (state_reg.win1 & WIN_ODD_WMASK);
    assign win3_view = is64_23 ? state_reg.win3 : (state_reg.win3 & WIN_ODD_WMASK);

    // Read mux
    always_comb begin
        rdata = 32'h0;
        if (cfg_req_in.addr == OFF_LINK_STAT2) begin
            rdata[LS_DEEMPH]                 = state_reg.deemph;
            rdata[LS_EQ_DONE]                = state_reg.eq_done;
            rdata[LS_EQ_PH1 +: 3]            = state_reg.eq_phase_ok;
            rdata[LS_EQ_REQ]                 = state_reg.eq_req;
            rdata[LS_PRES_LO +: 3]           = state_reg.presence;
            rdata[LS_DRS]                    = state_reg.drs_rx;
        end else if (cfg_req_in.addr == OFF_SUBSYS_HDR) begin
            rdata = {16'h0, SUBSYS_NEXT, SUBSYS_CAP_ID};
        end else if (cfg_req_in.addr == OFF_SUBSYS_CODE) begin
            rdata = {SUBSYS_DEVICE_CODE, SUBSYS_VENDOR_CODE};
        end else if (cfg_req_in.addr == OFF_MSIX_CTRL) begin
            rdata = {state_reg.msix_en, state_reg.msix_fmask, 3'h0, MSIX_TABLE_SIZE,
                     MSIX_NEXT, MSIX_CAP_ID};
        end else if (cfg_req_in.addr == OFF_MSIX_TABLE) begin
            rdata = {MSIX_TABLE_OFS, MSIX_WIN_IND};
        end else if (cfg_req_in.addr == OFF_MSIX_PEND) begin
            rdata = {MSIX_PEND_OFS, MSIX_WIN_IND};
        end else if (cfg_req_in.addr == OFF_VENDOR_HDR) begin
            rdata = {VENDOR_LEN, VENDOR_NEXT, VENDOR_CAP_ID};
        end else if (cfg_req_in.addr == OFF_WIN0) begin
            rdata = state_reg.win0;
        end else if (cfg_req_in.addr == OFF_WIN1) begin
            rdata = win1_view;
        end else if (cfg_req_in.addr == OFF_WIN2) begin
            rdata = state_reg.win2;
        end else if (cfg_req_in.addr == OFF_WIN3) begin
            rdata = win3_view;
        end
    end

    // Byte-lane merge of write data onto the addressed word
    always_comb begin
        merged = 32'h0;
        if (cfg_req_in.addr == OFF_WIN0) begin
            merged = (state_reg.win0 & ~wmask) | (cfg_req_in.wdata & wmask);
        end else if (cfg_req_in.addr == OFF_WIN1) begin
            merged = (state_reg.win1 & ~wmask) | (cfg_req_in.wdata & wmask);
        end else if (cfg_req_in.addr == OFF_WIN2) begin
            merged = (state_reg.win2 & ~wmask) | (cfg_req_in.wdata & wmask);
        end else if (cfg_req_in.addr == OFF_WIN3) begin
            merged = (state_reg.win3 & ~wmask) | (cfg_req_in.wdata & wmask);
        end else if (cfg_req_in.addr == OFF_MSIX_CTRL) begin
            merged = cfg_req_in.wdata & wmask;
        end
    end

    always_comb begin
        state_next = state_reg;

        // Link status mirrors
        state_next.deemph      = link_evt_in.deemph_35;
        state_next.eq_done     = link_evt_in.eq_done;
        state_next.eq_phase_ok = link_evt_in.eq_phase_ok;
        if (link_evt_in.presence != 3'h3 && link_evt_in.presence[2:1] != 2'h3) begin
            state_next.presence = link_evt_in.presence;
        end

        // Write-one-to-clear flags; a same-cycle event wins
        if (wr_hit && cfg_req_in.addr == OFF_LINK_STAT2) begin
            if (cfg_req_in.be[2] && cfg_req_in.wdata[LS_EQ_REQ]) begin
                state_next.eq_req = 1'b0;
            end
            if (cfg_req_in.be[3] && cfg_req_in.wdata[LS_DRS]) begin
                state_next.drs_rx = 1'b0;
            end
        end
        if (link_evt_in.eq_req_pulse) begin
            state_next.eq_req = 1'b1;
        end
        if (link_evt_in.drs_msg_pulse) begin
            state_next.drs_rx = 1'b1;
        end

        if (wr_hit) begin
            if (cfg_req_in.addr == OFF_MSIX_CTRL && cfg_req_in.be[3]) begin
                state_next.msix_fmask = merged[MSIX_FMASK_BIT];
                state_next.msix_en    = merged[MSIX_EN_BIT];
            end else if (cfg_req_in.addr == OFF_WIN0) begin
                // Illegal type codes leave the type unchanged
                if (merged[2:1] == WTYPE_32 || merged[2:1] == WTYPE_64) begin
                    state_next.win0 = merged & WIN0_WMASK;
                end else begin
                    state_next.win0 = {merged[31:3], state_reg.win0[2:1], 1'b0} & WIN0_WMASK;
                end
                // Leaving 64-bit mode must not expose an illegal fabric number
                if (state_next.win0[2:1] == WTYPE_32 && state_reg.win1[8:5] > FABRIC_MAX) begin
                    state_next.win1[8:5] = 4'h0;
                end
            end else if (cfg_req_in.addr == OFF_WIN1) begin
                if (is64_01) begin
                    state_next.win1 = merged;
                end else if (merged[8:5] <= FABRIC_MAX) begin
                    state_next.win1 = merged & WIN_ODD_WMASK;
                end else begin
                    state_next.win1 = {merged[31:9], state_reg.win1[8:5], merged[4:0]} & WIN_ODD_WMASK;
                end
            end else if (cfg_req_in.addr == OFF_WIN2) begin
                state_next.win2 = merged & WIN2_WMASK;
                if (!(merged[2:1] == WTYPE_32 || merged[2:1] == WTYPE_64)) begin
                    state_next.win2[2:1] = state_reg.win2[2:1];
                end
                if (merged[8:5] > PARTITION_MAX) begin
                    state_next.win2[8:5] = state_reg.win2[8:5];
                end
            end else if (cfg_req_in.addr == OFF_WIN3) begin
                if (is64_23) begin
                    state_next.win3 = merged;
                end else begin
                    state_next.win3 = merged & WIN_ODD_WMASK;
                end
            end
        end

        // Access answer; unmapped reads return zero, writes are dropped
        state_next.rsp.ack   = cfg_req_in.valid;
        state_next.rsp.rdata = rd_hit ? rdata : 32'h0;

        // Interrupt steering
        state_next.msix.enable        = state_reg.msix_en;
        state_next.msix.func_mask     = state_reg.msix_fmask;
        state_next.msix.msix_allowed  = state_reg.msix_en && !msi_enable_in;
        state_next.msix.intx_allowed  = !(state_reg.msix_en && !msi_enable_in);
        state_next.msix.vector_masked = vector_mask_in | {MSIX_VECTORS{state_reg.msix_fmask}};

        // Window decode
        state_next.win.pair64           = {is64_23, is64_01};
        state_next.win.trans_direct     = state_reg.win2[4];
        state_next.win.fabric_number    = state_reg.win1[8:5];
        state_next.win.partition_number = state_reg.win2[8:5];
        if (is64_01) begin
            state_next.win.enable[1:0]   = {2{state_reg.win1[31]}};
            state_next.win.prefetch[1:0] = {2{state_reg.win0[3]}};
            state_next.win.mask01 = state_reg.win1[31] ?
                {state_reg.win1, state_reg.win0[31:19], 19'h0} : 64'h0;
            state_next.win.mask1  = 32'h0;
        end else begin
            state_next.win.enable[1:0]   = {state_reg.win1[31], state_reg.win0[31]};
            state_next.win.prefetch[1:0] = {state_reg.win1[3], state_reg.win0[3]};
            state_next.win.mask01 = state_reg.win0[31] ?
                {33'h0, state_reg.win0[30:19], 19'h0} : 64'h0;
            state_next.win.mask1  = state_reg.win1[31] ? {1'b0, state_reg.win1[30:20], 20'h0} : 32'h0;
        end
        if (is64_23) begin
            state_next.win.enable[3:2]   = {2{state_reg.win3[31]}};
            state_next.win.prefetch[3:2] = {2{state_reg.win2[3]}};
            state_next.win.mask23 = state_reg.win3[31] ?
                {state_reg.win3, state_reg.win2[31:20], 20'h0} : 64'h0;
            state_next.win.mask3  = 32'h0;
        end else begin
            state_next.win.enable[3:2]   = {state_reg.win3[31], state_reg.win2[31]};
            state_next.win.prefetch[3:2] = {state_reg.win3[3], state_reg.win2[3]};
            state_next.win.mask23 = state_reg.win2[31] ?
                {33'h0, state_reg.win2[30:20], 20'h0} : 64'h0;
            state_next.win.mask3  = state_reg.win3[31] ? {1'b0, state_reg.win3[30:20], 20'h0} : 32'h0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_reg             <= '0;
            state_reg.deemph      <= DEEMPH_RESET;
            state_reg.presence    <= PRES_DOWN_UNKNOWN;
            state_reg.win0        <= WIN0_RESET;
            state_reg.win1        <= WIN1_RESET;
            state_reg.win2        <= WIN2_RESET;
            state_reg.win3        <= WIN3_RESET;
            state_reg.msix.intx_allowed <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_rsp_out = state_reg.rsp;
    assign msix_out    = state_reg.msix;
    assign win_out     = state_reg.win;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    deemph_follows_a: assert property (link_evt_in.deemph_35 |=> state_reg.deemph)
        else $error("de-emphasis status did not follow");
    eq_req_set_a: assert property (link_evt_in.eq_req_pulse |=> state_reg.eq_req ##1 state_reg.eq_req || $past(wr_hit))
        else $error("equalization request not set");
    drs_clear_a: assert property (wr_hit && cfg_req_in.addr == OFF_LINK_STAT2 && cfg_req_in.be[3]
        && cfg_req_in.wdata[LS_DRS] && !link_evt_in.drs_msg_pulse |=> !state_reg.drs_rx)
        else $error("readiness flag not cleared");
    drs_hold_a: assert property (state_reg.drs_rx && !(wr_hit && cfg_req_in.wdata[LS_DRS]) |=> state_reg.drs_rx)
        else $error("readiness flag lost without a clear");
    presence_legal_a: assert property (state_reg.presence != 3'h3 && state_reg.presence[2:1] != 2'h3)
        else $error("reserved presence code shown");
    fmask_all_a: assert property (state_reg.msix_fmask |=> &msix_out.vector_masked)
        else $error("function mask did not mask all vectors");
    msix_gate_a: assert property (!state_reg.msix_en |=> !msix_out.msix_allowed && msix_out.intx_allowed)
        else $error("MSI-X allowed while disabled");
    hdr_read_a: assert property (cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == OFF_MSIX_CTRL
        |=> cfg_rsp_out.ack && cfg_rsp_out.rdata[26:0] == 27'h005_c811)
        else $error("MSI-X header read wrong");
    table_read_a: assert property (cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == OFF_MSIX_TABLE
        |=> cfg_rsp_out.rdata == 32'h0007_f000)
        else $error("table location read wrong");
    fabric_range_a: assert property (!is64_01 |-> state_reg.win1[8:5] <= FABRIC_MAX)
        else $error("fabric number out of range");
    partition_range_a: assert property (state_reg.win2[8:5] <= PARTITION_MAX)
        else $error("partition number out of range");
    pair_off_a: assert property (is64_01 && !state_reg.win1[31] |=> win_out.mask01 == 64'h0 && win_out.enable[1:0] == 2'h0)
        else $error("disabled pair still decodes");
    ack_timing_a: assert property (cfg_req_in.valid |=> cfg_rsp_out.ack ##1 !cfg_rsp_out.ack || $past(cfg_req_in.valid))
        else $error("answer not one cycle after request");

    // Link status
    deemph_low_a: assert property (!link_evt_in.deemph_35 |=> !state_reg.deemph)
        else $error("de-emphasis stuck high");
    eq_done_a: assert property (link_evt_in.eq_done |=> state_reg.eq_done)
        else $error("equalization done not shown");
    phase_mirror_a: assert property (1'b1 |=> state_reg.eq_phase_ok == $past(link_evt_in.eq_phase_ok))
        else $error("phase status wrong");
    eq_req_clear_a: assert property (wr_hit && cfg_req_in.addr == OFF_LINK_STAT2 && cfg_req_in.be[2]
        && cfg_req_in.wdata[LS_EQ_REQ] && !link_evt_in.eq_req_pulse |=> !state_reg.eq_req)
        else $error("equalization request not cleared");
    eq_req_hold_a: assert property (state_reg.eq_req && !(wr_hit && cfg_req_in.wdata[LS_EQ_REQ])
        |=> state_reg.eq_req)
        else $error("equalization request lost");
    drs_set_a: assert property (link_evt_in.drs_msg_pulse |=> state_reg.drs_rx)
        else $error("readiness flag not set");
    presence_hold_a: assert property (link_evt_in.presence == 3'h3 |=> $stable(state_reg.presence))
        else $error("reserved presence code taken");

    // Fixed reads and answers
    subsys_read_a: assert property (rd_hit && cfg_req_in.addr == OFF_SUBSYS_HDR
        |=> cfg_rsp_out.rdata == 32'h0000_b00d)
        else $error("subsystem header wrong");
    pend_read_a: assert property (rd_hit && cfg_req_in.addr == OFF_MSIX_PEND
        |=> cfg_rsp_out.rdata == 32'h0007_f080)
        else $error("pending array location wrong");
    vendor_read_a: assert property (rd_hit && cfg_req_in.addr == OFF_VENDOR_HDR
        |=> cfg_rsp_out.rdata == 32'h0038_0009)
        else $error("vendor header wrong");
    write_quiet_a: assert property (wr_hit |=> cfg_rsp_out.ack && cfg_rsp_out.rdata == 32'h0)
        else $error("write answer carried data");
    idle_quiet_a: assert property (!cfg_req_in.valid |=> !cfg_rsp_out.ack && cfg_rsp_out.rdata == 32'h0)
        else $error("answer without request");

    // Interrupt steering
    vector_own_a: assert property (!state_reg.msix_fmask |=> msix_out.vector_masked == $past(vector_mask_in))
        else $error("vector mask not followed");
    msix_on_a: assert property (state_reg.msix_en && !msi_enable_in
        |=> msix_out.msix_allowed && !msix_out.intx_allowed)
        else $error("MSI-X not allowed");

    // Window setup
    type_legal_a: assert property (!state_reg.win0[1] && !state_reg.win2[1])
        else $error("illegal window type stored");
    prefetch_out_a: assert property (!is64_01 |=> win_out.prefetch[0] == $past(state_reg.win0[3]))
        else $error("prefetch not shown");
    win0_rsvd_a: assert property (state_reg.win0[18:4] == 15'h0 && !state_reg.win0[0])
        else $error("window 0 reserved bits set");
    enable32_a: assert property (!is64_01 |=> win_out.enable[0] == $past(state_reg.win0[31]))
        else $error("window 0 enable not shown");
    pair_upper_a: assert property (is64_01 && state_reg.win1[31]
        |=> win_out.mask01[63:32] == $past(state_reg.win1))
        else $error("odd word not upper half");
    trans_mode_a: assert property (1'b1 |=> win_out.trans_direct == $past(state_reg.win2[4]))
        else $error("translation mode not shown");
    win2_rsvd_a: assert property (state_reg.win2[19:9] == 11'h0 && !state_reg.win2[0])
        else $error("window 2 reserved bits set");

    pair64_cov_c: cover property (is64_01 && state_reg.win1[31]);
    flag_clear_cov_c: cover property (state_reg.eq_req ##1 !state_reg.eq_req);
    fabric_keep_cov_c: cover property (wr_hit && cfg_req_in.addr == OFF_WIN1 && cfg_req_in.wdata[8:5] > FABRIC_MAX);
    drs_clear_cov_c: cover property (state_reg.drs_rx ##1 !state_reg.drs_rx);
    fmask_cov_c: cover property (state_reg.msix_fmask && state_reg.msix_en);

endmodule

`default_nettype wire

// ---- verification/spc_host_model.sv ----
// Purpose: Requester model issuing configuration accesses
// Assumes: One access in flight, answer one cycle after the take
// Notes:   Released fields are inverted so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
    import spc_pkg::*;
(
    // Clock
    input  wire logic                  core_clk_in,
    // Request and answer
    output var spc_pkg::spc_cfg_req_s  cfg_req_out,
    input  wire spc_pkg::spc_cfg_rsp_s cfg_rsp_in
);
    initial cfg_req_out = '0;

    // Gap sets prompt or slow issue
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input int gap,
                          output logic [32:0] ans);
        repeat (gap) @(negedge core_clk_in);
        @(negedge core_clk_in);
        cfg_req_out <= '{1'b1, wr, a, 4'hf, d};
        @(negedge core_clk_in);
        ans = {cfg_rsp_in.ack, cfg_rsp_in.rdata};
        cfg_req_out <= '{1'b0, ~wr, ~a, 4'h0, ~d};
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the port configuration bank
// Assumes: Answer one cycle after take, derived outputs one cycle later
// Notes:   Random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import spc_pkg::*;
    logic          clk, srst, msi_en;
    logic [5:0]    vmask;
    spc_link_evt_s evt;
    spc_cfg_req_s  req;
    spc_cfg_rsp_s  rsp;
    spc_msix_s     msix;
    spc_win_s      win;
    logic [32:0]   ans;
    logic [31:0]   w, w2;
    logic [3:0]    f;
    logic          al;
    int            fails = 0, n_checks = 0, cyc = 0;
    logic [2:0]    pres [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};

    spc_cfg_regs uut (.core_clk_in(clk), .srst_in(srst), .cfg_req_in(req), .cfg_rsp_out(rsp),
        .link_evt_in(evt), .msi_enable_in(msi_en), .vector_mask_in(vmask), .msix_out(msix), .win_out(win));
    spc_host_model host (.core_clk_in(clk), .cfg_req_out(req), .cfg_rsp_in(rsp));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] ls_exp(spc_link_evt_s e, logic rq, logic drs);
        return {drs, e.presence, 6'h0, rq, e.eq_phase_ok, e.eq_done, e.deemph_35, 16'h0};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        host.access(1'b0, a, 32'h0, $urandom % 2, ans);
        chk(ans, {1'b1, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.access(1'b1, a, d, 0, ans);
        chk(ans, {1'b1, 32'h0});
    endtask

    task automatic end_of_test;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        srst = 1'b1;
        msi_en = 1'b0;
        vmask = '0;
        evt = '0;
        evt.deemph_35 = 1'b1;
        void'($urandom(70985));
        repeat (6) @(negedge clk);
        srst = 1'b0;
        rd_chk(8'h98, 32'h0001_0000);
        rd_chk(8'ha4, 32'h0000_b00d);
        rd_chk(8'ha8, 32'h2222_1111);
        rd_chk(8'hb0, 32'h0005_c811);
        rd_chk(8'hb4, {29'h0000_fe00, 3'h0});
        rd_chk(8'hb8, {29'h0000_fe10, 3'h0});
        rd_chk(8'hc8, 32'h0038_0009);
        rd_chk(8'he0, 32'hfff8_0000);
        rd_chk(8'he4, 32'h0);
        rd_chk(8'he8, 32'hfff0_0000);
        rd_chk(8'hec, 32'h0);
        rd_chk(8'hfc, 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) begin
            w = $urandom;
            evt = '{w[0], w[1], w[4:2], 1'b0, pres[i % 5], 1'b0};
            rd_chk(8'h98, ls_exp(evt, 1'b0, 1'b0));
        end
        evt.presence = 3'h3;
        rd_chk(8'h98, ls_exp(evt, 1'b0, 1'b0) & 32'h8fff_ffff | 32'h5000_0000);
        evt.presence = 3'h4;
        $display("test link_status done");
        @(negedge clk);
        evt.eq_req_pulse = 1'b1;
        evt.drs_msg_pulse = 1'b1;
        @(negedge clk);
        evt.eq_req_pulse = 1'b0;
        evt.drs_msg_pulse = 1'b0;
        rd_chk(8'h98, ls_exp(evt, 1'b1, 1'b1));
        wr(8'h98, 32'h0);
        rd_chk(8'h98, ls_exp(evt, 1'b1, 1'b1));
        wr(8'h98, 32'h8000_0000);
        rd_chk(8'h98, ls_exp(evt, 1'b1, 1'b0));
        wr(8'h98, 32'h0020_0000);
        rd_chk(8'h98, ls_exp(evt, 1'b0, 1'b0));
        $display("test clear_flags done");
        for (int i = 0; i < 8; i++) begin
            w = {i[1:0], 30'h0};
            w2 = $urandom;
            msi_en = w2[0];
            vmask = w2[6:1];
            wr(8'hb0, w);
            @(negedge clk);
            al = w[31] & ~msi_en;
            chk(msix, {w[31], w[30], al, ~al, vmask | {6{w[30]}}});
            rd_chk(8'hb0, {w[31:30], 14'h0005, 16'hc811});
        end
        $display("test msix done");
        for (int i = 0; i < 6; i++) begin
            w = $urandom;
            w[2:1] = 2'h0;
            wr(8'he0, w);
            rd_chk(8'he0, w & 32'hfff8_000e);
            w2 = $urandom;
            w2[2:1] = 2'h0;
            w2[8:5] = 4'($urandom % 12);
            wr(8'he8, w2);
            rd_chk(8'he8, w2 & 32'hfff0_01fe);
            @(negedge clk);
            chk({win.enable[0], win.enable[2], win.prefetch[0], win.trans_direct, win.partition_number, win.pair64},
                {w[31], w2[31], w[3], w2[4], w2[8:5], 2'h0});
            chk(win.mask01, w[31] ? {33'h0, w[30:19], 19'h0} : 64'h0);
            chk(win.mask23, w2[31] ? {33'h0, w2[30:20], 20'h0} : 64'h0);
            f = w2[8:5];
            w2[8:5] = 4'hc;
            wr(8'he8, w2);
            @(negedge clk);
            chk(win.partition_number, f);
        end
        $display("test windows done");
        wr(8'he0, 32'h8018_000c);
        w = $urandom | 32'h8000_0000;
        wr(8'he4, w);
        rd_chk(8'he4, w);
        @(negedge clk);
        chk({win.pair64[0], win.enable[1:0], win.prefetch[1:0]}, {1'b1, 4'hf});
        chk(win.mask01, {w, 32'h8018_0000});
        wr(8'he4, w & 32'h7fff_ffff);
        @(negedge clk);
        chk(win.mask01 | win.enable[1:0], 64'h0);
        wr(8'he0, 32'h0);
        wr(8'he4, 32'h8010_00a8);
        @(negedge clk);
        chk({win.mask1, win.enable[1], win.prefetch[1], win.fabric_number}, {32'h0010_0000, 2'h3, 4'h5});
        wr(8'he4, 32'h0000_00c0);
        rd_chk(8'he4, 32'h0000_00a0);
        $display("test pair64 done");
        end_of_test();
    end
endmodule
`default_nettype wire
